// ---- ssvd_consts.vh ----
/*
  Constants for the slow-scan video digitizer: register offsets,
  field positions, reset values and timing counts.
  Assumes a 40 MHz system clock.
*/
`ifndef SSVD_CONSTS_VH
`define SSVD_CONSTS_VH

`define SSVD_CLK_HZ        40000000
`define SSVD_CLK_MHZ       40
// Host lines on the game-port byte
`define SSVD_BIT_SYNC      7
`define SSVD_BIT_LEVEL     6
`define SSVD_BIT_SWEEP     5
`define SSVD_THR_W         4
// Sync stretch time in ns; horizontal sync itself is about 4700 ns
`define SSVD_HSYNC_NS      4700
`define SSVD_STRETCH_NS    12000
`define SSVD_STRETCH_CYC   ((`SSVD_STRETCH_NS * `SSVD_CLK_MHZ + 999) / 1000)
// Sample window start after sync start, in ns
`define SSVD_SAMPLE_BASE_NS 12000
`define SSVD_SAMPLE_BASE_CYC ((`SSVD_SAMPLE_BASE_NS * `SSVD_CLK_MHZ + 999) / 1000)
// Register map, byte addresses
`define SSVD_ADDR_W        4
`define SSVD_REG_RAMP      4'h0
`define SSVD_REG_STATUS    4'h4
`define SSVD_REG_DELAY     4'h8
`define SSVD_REG_LINES     4'hc
// Ramp step per scanline, 8 fractional bits (about one column per 43 lines); threshold step per code
`define SSVD_RAMP_RESET    8'h06
`define SSVD_THR_STEP      8'h08
// Status fields
`define SSVD_ST_SWEEP      0
`define SSVD_ST_LEVEL      1
`define SSVD_ST_SYNC       2

`endif

// ---- ssvd_host_model.sv ----
/* Host side: drives sweep and threshold lines, polls sense lines.
   Assumes the bench sets the requests. */
`timescale 1ns/10ps
module ssvd_host_model (
  input  wire        clk_sys,
  input  wire        sweep_req,
  input  wire [3:0]  thr_req,
  input  wire        host_sync_sense,
  input  wire        host_level_sense,
  output reg         host_sweep_pin = 1'b0,
  output reg  [3:0]  host_thr_pin = 4'h0,
  output reg         seen_level = 1'b0,
  output reg  [15:0] low_len = 16'h0000
);
  reg sync_q = 1'b1;
  always @(posedge clk_sys) begin
    host_sweep_pin <= sweep_req;
    host_thr_pin   <= thr_req;
    sync_q         <= host_sync_sense;
    if (sync_q && !host_sync_sense) begin
      seen_level <= host_level_sense;
      low_len    <= 16'h0001;
    end else if (!host_sync_sense) begin
      low_len <= low_len + 16'h0001;
    end
  end
endmodule

// ---- ssvd_pin_sync.v ----
/*
  Three-flop input synchroniser for a group of pins, one generate
  slice per bit. Output changes once stages two and three agree.
  Assumes the pins are asynchronous to clk_sys.
*/
`timescale 1ns/10ps
module ssvd_pin_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire         rst_n,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] pin_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg out_reg;
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg  <= 1'b0;
          s2_reg  <= 1'b0;
          s3_reg  <= 1'b0;
          out_reg <= 1'b0;
        end else begin
          s1_reg <= pin_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // Glitch filter: only a settled value is taken
          if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
          end
        end
      end
      assign pin_out[i] = out_reg;
    end
  endgenerate
endmodule

// ---- ssvd_top.v ----
/*
  Slow-scan video digitizer core: sync stretching, per-line sampling
  with a continuously ramped delay, threshold compare, game-port lines.
  Assumes an external sync slicer pin and a video ADC clocked by clk_sys.
*/
`timescale 1ns/10ps
`include "ssvd_consts.vh"
module ssvd_top #(
  parameter VID_W   = 8,
  parameter DELAY_W = 12,
  parameter FRAC_W  = 8
) (
  input  wire                    clk_sys,
  input  wire                    resetn,
  input  wire                    vid_sync_n_pin,
  input  wire [VID_W-1:0]        vid_level,
  input  wire [VID_W-1:0]        knob_level,
  input  wire                    host_sweep_pin,
  input  wire [`SSVD_THR_W-1:0]  host_thr_pin,
  output reg                     host_sync_sense,
  output reg                     host_level_sense,
  input  wire [`SSVD_ADDR_W-1:0] reg_addr,
  input  wire [31:0]             reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [31:0]             reg_rdata
);
  localparam [15:0] STRETCH_CYC = `SSVD_STRETCH_CYC;
  localparam [15:0] BASE_CYC    = `SSVD_SAMPLE_BASE_CYC;
  localparam        ACC_W       = DELAY_W + FRAC_W;

  reg rst_s1_reg;
  reg rst_s2_reg;
  wire rst_n = rst_s2_reg;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // Pins from the video slicer and from the host port
  wire [`SSVD_THR_W+1:0] pins_sync;
  ssvd_pin_sync #(
    .W (`SSVD_THR_W + 2)
  ) u_pins (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  ({vid_sync_n_pin, host_sweep_pin, host_thr_pin}),
    .pin_out (pins_sync)
  );
  wire                   sync_lvl = ~pins_sync[`SSVD_THR_W+1];
  wire                   sweep    = pins_sync[`SSVD_THR_W];
  wire [`SSVD_THR_W-1:0] thr_code = pins_sync[`SSVD_THR_W-1:0];

  reg                 sync_d_reg;
  reg  [15:0]         stretch_reg;
  reg  [15:0]         line_cnt_reg;
  reg                 armed_reg;
  reg  [ACC_W-1:0]    ramp_acc_reg;
  reg  [7:0]          ramp_step_reg;
  reg  [15:0]         lines_reg;
  reg  [VID_W:0]      thr_reg;

  wire sync_start = sync_lvl & ~sync_d_reg;
  wire [15:0] sample_at = BASE_CYC + {{(16-DELAY_W){1'b0}}, ramp_acc_reg[ACC_W-1:FRAC_W]};
  wire sample_now = armed_reg & (line_cnt_reg == sample_at);

  // Threshold: knob plus code steps; one extra bit keeps the top codes from wrapping
  always @* begin
    thr_reg = {1'b0, knob_level} + {1'b0, thr_code * `SSVD_THR_STEP};
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_d_reg       <= 1'b0;
      stretch_reg      <= 16'h0000;
      line_cnt_reg     <= 16'h0000;
      armed_reg        <= 1'b0;
      ramp_acc_reg     <= {ACC_W{1'b0}};
      lines_reg        <= 16'h0000;
      host_sync_sense  <= 1'b0;
      host_level_sense <= 1'b0;
    end else begin
      sync_d_reg <= sync_lvl;
      // Hold while sync lasts, then run out; long vsync shows as long low
      if (sync_lvl) begin
        stretch_reg <= STRETCH_CYC;
      end else if (stretch_reg != 16'h0000) begin
        stretch_reg <= stretch_reg - 16'h0001;
      end
      if (sync_start) begin
        line_cnt_reg <= 16'h0000;
        armed_reg    <= sweep;
      end else begin
        if (line_cnt_reg != 16'hffff) begin
          line_cnt_reg <= line_cnt_reg + 16'h0001;
        end
        if (sample_now) begin
          armed_reg <= 1'b0;
        end
      end
      if (!sweep) begin
        ramp_acc_reg     <= {ACC_W{1'b0}};
        lines_reg        <= 16'h0000;
        host_sync_sense  <= 1'b0;
        host_level_sense <= 1'b0;
      end else begin
        // Every line adds a fraction of a column, so the skew is continuous
        if (sync_start) begin
          ramp_acc_reg <= ramp_acc_reg + {{(ACC_W-8){1'b0}}, ramp_step_reg};
          lines_reg    <= lines_reg + 16'h0001;
        end
        host_sync_sense <= ~(sync_lvl | (stretch_reg != 16'h0000));
        if (sample_now) begin
          host_level_sense <= ({1'b0, vid_level} > thr_reg);
        end
      end
    end
  end

  // Register port
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ramp_step_reg <= `SSVD_RAMP_RESET;
      reg_rdata     <= 32'h00000000;
    end else begin
      if (reg_wr && reg_addr == `SSVD_REG_RAMP) begin
        ramp_step_reg <= reg_wdata[7:0];
      end
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `SSVD_REG_RAMP:   reg_rdata <= {24'h000000, ramp_step_reg};
          `SSVD_REG_STATUS: reg_rdata <= {29'h00000000, host_sync_sense,
                                          host_level_sense, sweep};
          `SSVD_REG_DELAY:  reg_rdata <= {{(32-DELAY_W){1'b0}},
                                          ramp_acc_reg[ACC_W-1:FRAC_W]};
          `SSVD_REG_LINES:  reg_rdata <= {16'h0000, lines_reg};
          default:          reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ---- ssvd_top_sva.sv ----
/* Checker on the sense lines and register port.
   Assumes one clock domain, bound to ssvd_top. */
`timescale 1ns/10ps
`include "ssvd_consts.vh"
module ssvd_top_sva (
  input wire                    clk_sys,
  input wire                    resetn,
  input wire                    vid_sync_n_pin,
  input wire                    host_sweep_pin,
  input wire                    host_sync_sense,
  input wire                    host_level_sense,
  input wire                    reg_rd,
  input wire [`SSVD_ADDR_W-1:0] reg_addr,
  input wire [31:0]             reg_rdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence run_s;
    host_sweep_pin[*8];
  endsequence
  sequence off_s;
    (!host_sweep_pin)[*8];
  endsequence
  off_quiet_a: assert property (
    off_s |-> !host_sync_sense && !host_level_sense)
    else $error("sense active, sweep off");
  sync_low_a: assert property (
    run_s ##0 $fell(vid_sync_n_pin) |-> ##[2:8] !host_sync_sense)
    else $error("sync missed");
  stretch_a: assert property (
    run_s ##0 $rose(vid_sync_n_pin) |-> ##300 !host_sync_sense)
    else $error("sync short");
  level_gate_a: assert property (
    $rose(host_level_sense) |-> $past(host_sweep_pin, 3))
    else $error("level early");
  sync_gate_a: assert property (
    $rose(host_sync_sense) |-> $past(host_sweep_pin, 3) && vid_sync_n_pin)
    else $error("sync early");
  rd_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("stray read data");
  delay_clr_a: assert property (
    off_s ##0 (reg_rd && reg_addr == `SSVD_REG_DELAY) |=> reg_rdata == 32'h00000000)
    else $error("delay kept");
  lines_clr_a: assert property (
    off_s ##0 (reg_rd && reg_addr == `SSVD_REG_LINES) |=> reg_rdata == 32'h00000000)
    else $error("lines kept");
  cover property (run_s ##0 $rose(host_level_sense));
  cover property (run_s ##0 $fell(host_sync_sense));
  cover property (reg_rd && reg_addr == `SSVD_REG_LINES);
endmodule
bind ssvd_top ssvd_top_sva ssvd_top_sva_inst (.clk_sys(clk_sys), .resetn(resetn),
  .vid_sync_n_pin(vid_sync_n_pin), .host_sweep_pin(host_sweep_pin), .reg_rd(reg_rd),
  .host_sync_sense(host_sync_sense), .host_level_sense(host_level_sense),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata));

// ---- tb_ssvd_top.sv ----
/* Bench: register tasks, video line source, host model.
   Assumes a 40 MHz clock. */
`timescale 1ns/10ps
`include "ssvd_consts.vh"
module tb_ssvd_top;
  localparam int LINE = 1300;
  logic        clk_sys = 1'b0, resetn = 1'b0, vid_sync_n_pin = 1'b1, sweep_req = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, sweep_pin, sync_s, level_s, seen_level;
  logic [7:0]  vid_level = 8'h00, knob = 8'h40;
  logic [3:0]  thr_pin, thr_req = 4'h0, reg_addr = 4'h0;
  logic [15:0] low_len;
  logic [31:0] reg_wdata = 32'h00000000, reg_rdata;
  int          error_cnt = 0, checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  ssvd_top ssvd_top_inst (.clk_sys(clk_sys), .resetn(resetn), .vid_sync_n_pin(vid_sync_n_pin),
    .vid_level(vid_level), .knob_level(knob), .host_sweep_pin(sweep_pin),
    .host_thr_pin(thr_pin), .host_sync_sense(sync_s), .host_level_sense(level_s),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  ssvd_host_model ssvd_host_model_inst (.clk_sys(clk_sys), .sweep_req(sweep_req),
    .thr_req(thr_req), .host_sync_sense(sync_s), .host_level_sense(level_s),
    .host_sweep_pin(sweep_pin), .host_thr_pin(thr_pin), .seen_level(seen_level),
    .low_len(low_len));
  task automatic cmpw(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmpb(input string what, input logic exp, input logic got);
    cmpw(what, {31'h00000000, exp}, {31'h00000000, got});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 cmpw(what, exp, reg_rdata);
  endtask
  // One scanline; ends 1 ns after an edge so outputs have settled
  task automatic line(input logic [7:0] lvl, input int low);
    @(posedge clk_sys);
    vid_sync_n_pin <= 1'b0;
    vid_level      <= lvl;
    repeat (low) @(posedge clk_sys);
    vid_sync_n_pin <= 1'b1;
    repeat (LINE - low - 1) @(posedge clk_sys);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdc("ramp", `SSVD_REG_RAMP, 32'h00000006);
    wr(`SSVD_REG_RAMP, 32'h00000040);
    rdc("ramp", `SSVD_REG_RAMP, 32'h00000040);
    wr(`SSVD_REG_STATUS, 32'h00000007);
    rdc("status", `SSVD_REG_STATUS, 32'h00000000);
    rdc("unmapped", 4'h2, 32'h00000000);
    line(8'hff, 188);
    cmpb("sync off", 1'b0, sync_s);
    cmpb("level off", 1'b0, level_s);
    line(8'h00, 600);
    sweep_req <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      thr_req <= 4'(c);
      line(knob + 8'(c * 8) + 8'h01, 188);
      cmpb("level hi", 1'b1, level_s);
      cmpb("sync idle", 1'b1, sync_s);
      line(knob + 8'(c * 8), 188);
      cmpb("level eq", 1'b0, level_s);
      cmpb("held", 1'b1, seen_level);
      cmpb("stretch", 1'b1, low_len > 16'h0258 && low_len < 16'h02bc);
    end
    line(8'h00, 600);
    cmpb("vsync", 1'b1, low_len > 16'h03e8);
    rdc("lines", `SSVD_REG_LINES, 32'h00000021);
    rdc("delay", `SSVD_REG_DELAY, 32'h00000008);
    sweep_req <= 1'b0;
    repeat (10) @(posedge clk_sys);
    #1 cmpb("sync off", 1'b0, sync_s);
    rdc("delay", `SSVD_REG_DELAY, 32'h00000000);
    rdc("lines", `SSVD_REG_LINES, 32'h00000000);
    complete_run();
  end
endmodule
